/* imsc_top.sv */
// Interrupt enable mask block with AXI4-Lite register access.
// Assumes cause bits, auto-mask value and cause-read strobe come from
// neighbouring logic on ref_clk; timer logic acts on timer_clear.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module imsc_top
  import imsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] cause_bits,
  input  wire logic        cause_int_asserted,
  input  wire logic        cause_read_strobe,
  input  wire logic [31:0] auto_mask_value,
  output logic             irq_to_host,
  output logic             timer_clear,
  output logic             evt_irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] strobe_bits(input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      IMSC_OFS_MASK_SET,
      IMSC_OFS_MASK_CLR,
      IMSC_OFS_CTRL,
      IMSC_OFS_EVT_STATUS,
      IMSC_OFS_EVT_MASK: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                 aw_held;
  logic [11:0]          aw_addr;
  logic                 w_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 wr_go;
  logic [31:0]          wr_bits;
  logic                 rd_go;
  logic [31:0]          mask;
  logic [31:0]          set_bits;
  logic [31:0]          clr_bits;
  logic [31:0]          ctrl;
  logic [IMSC_EVT_W-1:0] evt_status;
  logic [IMSC_EVT_W-1:0] evt_mask;
  logic [IMSC_EVT_W-1:0] evt_hits;
  logic [IMSC_EVT_W-1:0] evt_clr;
  logic                 auto_mask_go;
  logic                 timer_go;
  logic                 next_irq;

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_bits       = strobe_bits(w_data, w_strb);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[11:2], 2'h0};
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= IMSC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(aw_addr) ? IMSC_RESP_OKAY
                                           : IMSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Mask set and clear requests
  // ****************************************************************
  // Auto-mask acts only when the cause read found an asserted interrupt
  assign auto_mask_go = cause_read_strobe && cause_int_asserted
                        && ctrl[IMSC_CTRL_AUTO_MASK];

  always_comb begin
    set_bits = 32'h00000000;
    clr_bits = 32'h00000000;
    if (wr_go && (aw_addr == IMSC_OFS_MASK_SET)) begin
      set_bits = wr_bits;
    end
    if (wr_go && (aw_addr == IMSC_OFS_MASK_CLR)) begin
      clr_bits = wr_bits;
    end
    if (auto_mask_go) begin
      clr_bits = clr_bits | auto_mask_value;
    end
  end

  imsc_mask_reg imsc_mask_reg_i (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .set_bits (set_bits),
    .clr_bits (clr_bits),
    .mask     (mask)
  );

  // ****************************************************************
  // Delay timer clear on enable-all write
  // ****************************************************************
  assign timer_go = wr_go && (aw_addr == IMSC_OFS_MASK_SET)
                    && (w_strb == 4'hF) && (w_data == IMSC_ALL_ONES)
                    && ctrl[IMSC_CTRL_TIMER_CLR];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timer_clear <= 1'b0;
    end else begin
      timer_clear <= timer_go;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= IMSC_CTRL_RESET;
    end else if (wr_go && (aw_addr == IMSC_OFS_CTRL)) begin
      ctrl <= ((ctrl & ~strobe_bits(IMSC_ALL_ONES, w_strb)) | wr_bits)
              & IMSC_CTRL_DEFINED;
    end
  end

  // ****************************************************************
  // Host interrupt request
  // ****************************************************************
  // Each cause pairs with the mask bit of the same position
  assign next_irq = |(cause_bits & mask);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_to_host <= 1'b0;
    end else begin
      irq_to_host <= next_irq;
    end
  end

  // ****************************************************************
  // Block event status and interrupt
  // ****************************************************************
  always_comb begin
    evt_hits = IMSC_EVT_RESET;
    evt_hits[IMSC_EVT_TIMER_CLR] = timer_go;
    evt_hits[IMSC_EVT_AUTO_MASK] = auto_mask_go;
    evt_hits[IMSC_EVT_IRQ_RISE]  = next_irq && !irq_to_host;
  end

  assign evt_clr = (rd_go && (s_axi_araddr[11:2] == IMSC_OFS_EVT_STATUS[11:2]))
                   ? {IMSC_EVT_W{1'b1}} : IMSC_EVT_RESET;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evt_status <= IMSC_EVT_RESET;
    end else begin
      // A new event wins over the clearing read
      evt_status <= (evt_status & ~evt_clr) | evt_hits;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evt_mask <= IMSC_EVT_RESET;
    end else if (wr_go && (aw_addr == IMSC_OFS_EVT_MASK) && w_strb[0]) begin
      evt_mask <= w_data[IMSC_EVT_W-1:0];
    end
  end

  assign evt_irq = |(evt_status & evt_mask);

  // ****************************************************************
  // AXI4-Lite read channels
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= IMSC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rresp <= addr_mapped({s_axi_araddr[11:2], 2'h0})
                     ? IMSC_RESP_OKAY : IMSC_RESP_SLVERR;
      case ({s_axi_araddr[11:2], 2'h0})
        IMSC_OFS_MASK_SET: begin
          s_axi_rdata <= mask;
        end
        IMSC_OFS_CTRL: begin
          s_axi_rdata <= ctrl;
        end
        IMSC_OFS_EVT_STATUS: begin
          s_axi_rdata <= {29'h0000000, evt_status};
        end
        IMSC_OFS_EVT_MASK: begin
          s_axi_rdata <= {29'h0000000, evt_mask};
        end
        default: begin
          // Clear register is write-only and reads as zero
          s_axi_rdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule

/* imsc_pkg.sv */
// Constants and register map of the interrupt enable mask block.
// Assumes a 32-bit AXI4-Lite slave port on a single 50 MHz clock.
//
// Functional notes
// - Reading the set/read register returns the current enable mask.
// - Mask bit one enables its cause, zero disables it.
// - Interrupt presented only while some cause bit and its mask bit are one.
// - Interrupt conditions come from cause bits, paired by bit position.
// - Writing one to a set/read register bit sets that mask bit.
// - Zeros written to the set/read register leave mask bits unchanged.
// - Writing one to a clear register bit clears that mask bit.
// - Zeros to clear register change nothing; clear register is write-only.
// - With timer clear enabled, all-ones set write resets delay timers.
// - Mask bits 0,1,2,4,6,7,9 hold the first group of causes.
// - Mask bits 15 to 18 and 20 to 24 hold the remaining causes.
// - Defined mask bits reset to zero, all causes disabled.
// - Cause read with interrupt asserted and auto-mask applies auto-mask clear.
// - A cause set raises the interrupt when its mask bit is one.

package imsc_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int          IMSC_ADDR_W          = 12;
  localparam int          IMSC_DATA_W          = 32;
  localparam logic [11:0] IMSC_OFS_MASK_SET    = 12'h0D0;
  localparam logic [11:0] IMSC_OFS_MASK_CLR    = 12'h0D8;
  localparam logic [11:0] IMSC_OFS_CTRL        = 12'h100;
  localparam logic [11:0] IMSC_OFS_EVT_STATUS  = 12'h104;
  localparam logic [11:0] IMSC_OFS_EVT_MASK    = 12'h108;
  localparam logic [1:0]  IMSC_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  IMSC_RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Mask layout
  // ****************************************************************
  localparam int IMSC_BIT_TX_DESC_WRITTEN_BACK  = 0;
  localparam int IMSC_BIT_TX_QUEUE_EMPTY        = 1;
  localparam int IMSC_BIT_LINK_CHANGE           = 2;
  localparam int IMSC_BIT_RX_DESC_MIN_THRESHOLD = 4;
  localparam int IMSC_BIT_RX_OVERRUN            = 6;
  localparam int IMSC_BIT_RX_TIMER_IRQ          = 7;
  localparam int IMSC_BIT_MGMT_DATA_ACCESS_DONE = 9;
  localparam int IMSC_BIT_TX_DESC_LOW           = 15;
  localparam int IMSC_BIT_SMALL_RX_PACKET       = 16;
  localparam int IMSC_BIT_RX_ACK_FRAME          = 17;
  localparam int IMSC_BIT_MANAGEABILITY_EVENT   = 18;
  localparam int IMSC_BIT_RX_QUEUE_ZERO_IRQ     = 20;
  localparam int IMSC_BIT_RX_QUEUE_ONE_IRQ      = 21;
  localparam int IMSC_BIT_TX_QUEUE_ZERO_IRQ     = 22;
  localparam int IMSC_BIT_TX_QUEUE_ONE_IRQ      = 23;
  localparam int IMSC_BIT_OTHER_CAUSE           = 24;
  localparam logic [31:0] IMSC_MASK_DEFINED    = 32'h01F782D7;
  localparam logic [31:0] IMSC_MASK_RESET      = 32'h00000000;
  localparam logic [31:0] IMSC_ALL_ONES        = 32'hFFFFFFFF;

  // ****************************************************************
  // Control and event registers
  // ****************************************************************
  localparam int          IMSC_CTRL_TIMER_CLR  = 0;
  localparam int          IMSC_CTRL_AUTO_MASK  = 1;
  localparam logic [31:0] IMSC_CTRL_DEFINED    = 32'h00000003;
  localparam logic [31:0] IMSC_CTRL_RESET      = 32'h00000000;
  localparam int          IMSC_EVT_TIMER_CLR   = 0;
  localparam int          IMSC_EVT_AUTO_MASK   = 1;
  localparam int          IMSC_EVT_IRQ_RISE    = 2;
  localparam int          IMSC_EVT_W           = 3;
  localparam logic [2:0]  IMSC_EVT_RESET       = 3'h0;

endpackage

/* imsc_mask_reg.sv */
// Enable mask storage with write-one-to-set and write-one-to-clear ports.
// Assumes set and clear vectors are one-cycle requests on ref_clk.
`timescale 1ns/10ps

module imsc_mask_reg
  import imsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] set_bits,
  input  wire logic [31:0] clr_bits,
  output logic      [31:0] mask
);

  // ****************************************************************
  // Mask update, a clear in the same cycle as a set wins
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask <= IMSC_MASK_RESET;
    end else begin
      // Zeros in either vector keep the bit as it is
      mask <= ((mask | set_bits) & ~clr_bits)
              & IMSC_MASK_DEFINED;
    end
  end

endmodule

/* imsc_props.sv */
// Checker for the interrupt enable mask block, bound to imsc_top.
// Assumes AXI4-Lite masters that hold valid and payload until ready.
`timescale 1ns/10ps

module imsc_props
  import imsc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] cause_bits,
  input wire logic        irq_to_host,
  input wire logic        timer_clear
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  reset_quiet_a: assert property (
    !$past(nrst) |-> !irq_to_host)
    else $error("interrupt raised straight after reset");
  irq_cause_a: assert property (
    irq_to_host |-> $past(cause_bits) != 32'h0)
    else $error("interrupt without any cause bit");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after capture");
  timer_once_a: assert property (
    timer_clear |=> !timer_clear)
    else $error("timer clear longer than one cycle");
  timer_with_b_a: assert property (
    timer_clear |-> $rose(s_axi_bvalid))
    else $error("timer clear not with its write response");

  cover property (irq_to_host);
  cover property (timer_clear);
  cover property (s_axi_bvalid && s_axi_bresp == IMSC_RESP_SLVERR);
endmodule

bind imsc_top imsc_props imsc_props_i (.ref_clk, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cause_bits, .irq_to_host, .timer_clear);

/* imsc_host_sink.sv */
// Host side interrupt sink: counts interrupts delivered to the host.
// Assumes irq_to_host is a level on ref_clk.
`timescale 1ns/10ps

module imsc_host_sink
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic irq_to_host,
  output int        irq_count
);
  logic irq_seen;

  // Each rising edge of the request is one delivered interrupt
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_seen  <= 1'b0;
      irq_count <= 0;
    end else begin
      irq_seen <= irq_to_host;
      if (irq_to_host && !irq_seen) irq_count <= irq_count + 1;
    end
  end
endmodule

/* imsc_tb_top.sv */
// Self-checking bench for the interrupt enable mask block.
// Assumes one 50 MHz clock and AXI4-Lite register access.
`timescale 1ns/10ps

module imsc_tb_top
  import imsc_pkg::*;
;
  logic        ref_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, cause_int_asserted;
  logic        cause_read_strobe, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq_to_host, timer_clear, evt_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, cause_bits, auto_mask_value, s_axi_rdata, rd, exp;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  s_axi_wstrb;
  int          errors = 0, n_checks = 0, n_timer = 0, irq_count;
  int          bits[16] = '{0, 1, 2, 4, 6, 7, 9, 15, 16, 17, 18, 20, 21, 22,
                            23, 24};

  imsc_top imsc_top_i (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cause_bits,
    .cause_int_asserted, .cause_read_strobe, .auto_mask_value, .irq_to_host,
    .timer_clear, .evt_irq);
  imsc_host_sink imsc_host_sink_i (.ref_clk, .nrst, .irq_to_host, .irq_count);

  // ****************************************************************
  // Clock, counters and tasks
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (timer_clear === 1'b1) n_timer++;

  task automatic chk(input string what, input logic [31:0] seen, e);
    n_checks++;
    if (seen !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, done;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      // Values at the falling edge stand until the next rising edge
      @(negedge ref_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (done !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ta, done;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = s_axi_arvalid & s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (done !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic strobe_cause(input logic asserted);
    @(posedge ref_clk);
    cause_int_asserted <= asserted;
    cause_read_strobe <= 1'b1;
    @(posedge ref_clk);
    cause_read_strobe <= 1'b0;
    cause_int_asserted <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(20 * 5000);
    errors++;
    tally_and_finish();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, cause_int_asserted, cause_read_strobe} = 3'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr} = 24'h0;
    {s_axi_wdata, cause_bits, auto_mask_value} = 96'h0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rdr(IMSC_OFS_MASK_SET);
    chk("mask after reset", rd, 32'h0);
    cause_bits <= IMSC_ALL_ONES;
    settle();
    chk("irq all masked", {31'h0, irq_to_host}, 32'h0);
    $display("test reset done");

    cause_bits <= 32'h0;
    exp = 32'h0;
    foreach (bits[i]) exp[bits[i]] = 1'b1;
    wr(IMSC_OFS_MASK_SET, IMSC_ALL_ONES);
    chk("mask write resp", {30'h0, resp}, 32'h0);
    rdr(IMSC_OFS_MASK_SET);
    chk("mask all set", rd, exp);
    chk("mask read resp", {30'h0, resp}, 32'h0);
    wr(IMSC_OFS_MASK_SET, 32'h0);
    wr(IMSC_OFS_MASK_CLR, 32'h0);
    rdr(IMSC_OFS_MASK_SET);
    chk("mask after zero writes", rd, exp);
    rdr(IMSC_OFS_MASK_CLR);
    chk("clear reg reads", rd, 32'h0);
    foreach (bits[i]) begin
      wr(IMSC_OFS_MASK_CLR, 32'h1 << bits[i]);
      exp[bits[i]] = 1'b0;
      rdr(IMSC_OFS_MASK_SET);
      chk("mask clear bit", rd, exp);
    end
    $display("test set and clear done");

    cause_bits <= 32'h1 << IMSC_BIT_LINK_CHANGE;
    wr(IMSC_OFS_MASK_SET, 32'h1 << IMSC_BIT_RX_OVERRUN);
    settle();
    chk("irq other position", {31'h0, irq_to_host}, 32'h0);
    wr(IMSC_OFS_MASK_SET, 32'h1 << IMSC_BIT_LINK_CHANGE);
    settle();
    chk("irq enabled", {31'h0, irq_to_host}, 32'h1);
    wr(IMSC_OFS_MASK_CLR, 32'h1 << IMSC_BIT_LINK_CHANGE);
    settle();
    chk("irq disabled", {31'h0, irq_to_host}, 32'h0);
    chk("irq delivered", irq_count, 32'h1);
    $display("test interrupt line done");

    cause_bits <= 32'h0;
    rdr(IMSC_OFS_EVT_STATUS);
    wr(IMSC_OFS_EVT_MASK, 32'h1);
    wr(IMSC_OFS_MASK_SET, IMSC_ALL_ONES);
    chk("timer with enable off", n_timer, 32'h0);
    wr(IMSC_OFS_CTRL, 32'h1);
    wr(IMSC_OFS_MASK_SET, 32'hFFFFFFFE);
    chk("timer partial write", n_timer, 32'h0);
    s_axi_wstrb <= 4'h7;
    wr(IMSC_OFS_MASK_SET, IMSC_ALL_ONES);
    s_axi_wstrb <= 4'hF;
    chk("timer partial strobe", n_timer, 32'h0);
    wr(IMSC_OFS_MASK_SET, IMSC_ALL_ONES);
    settle();
    chk("timer pulses", n_timer, 32'h1);
    chk("event line", {31'h0, evt_irq}, 32'h1);
    rdr(IMSC_OFS_EVT_STATUS);
    chk("event status", rd, 32'h1);
    settle();
    chk("event line cleared", {31'h0, evt_irq}, 32'h0);
    $display("test timer clear done");

    exp = 32'h0;
    foreach (bits[i]) exp[bits[i]] = 1'b1;
    auto_mask_value <= 32'h1 << IMSC_BIT_RX_TIMER_IRQ;
    wr(IMSC_OFS_CTRL, 32'h2);
    strobe_cause(1'b0);
    rdr(IMSC_OFS_MASK_SET);
    chk("auto mask not asserted", rd, exp);
    strobe_cause(1'b1);
    exp[IMSC_BIT_RX_TIMER_IRQ] = 1'b0;
    rdr(IMSC_OFS_MASK_SET);
    chk("auto mask applied", rd, exp);
    $display("test auto mask done");

    wr(12'h0D4, IMSC_ALL_ONES);
    chk("unmapped write resp", {30'h0, resp}, 32'h2);
    rdr(12'hFFC);
    chk("unmapped read data", rd, 32'h0);
    chk("unmapped read resp", {30'h0, resp}, 32'h2);
    rdr(IMSC_OFS_MASK_SET);
    chk("mask kept", rd, exp);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
